// ### rtl/serial_port_defs.vh
// Register map, field positions, reset values and timing for the serial port
// Behaviour
// - Bit interval (n+1)x8/3 or x32/3, n nonzero
// - Hidden 11-bit transmit shifter fed from holding
// - Hidden 11-bit receive shifter drained to holding
// - Fixed-rate continuous mode stop-bit counts apply
// - Range bit picks coarse or fine divider
// - Start detect enable arms falling-edge detection
// - Falling edge sets running; stop bit clears
// - Low stop bit sets sticky stop error
// - Parity select: 0 even, 1 odd
// - Transmit appends computed parity automatically
// - Ninth-bit field holds bit 8 or parity error
// - Frame end loads holding, sets receive end
// - Receive interrupt when end flag and enable
// - Run bit starts, self-clears, clear aborts
// - Continuous mode restarts after one cycle
// - Transmit direction bit set blocks pin drive
// - Length bits select 8, 7, 9, 8+parity
// - Buffer empty set when holding copied out
// - Transmit interrupt when empty flag and enable
// - Mode field: programmable or fixed 9600/4800/2400
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Register indices; byte address is four times the index
`define RX_CTRL_IDX    16'hfed0
`define TX_CTRL_IDX    16'hfed1
`define BAUD_DIV_IDX   16'hfed2
`define TX_HOLD_IDX    16'hfed3
`define RX_HOLD_IDX    16'hfed4
`define MODE_SEL_IDX   16'hfed5
`define PORT_DIR_IDX   16'hfe4d

// Reset values
`define CTRL_RESET     8'h00

// Receive control fields
`define RC_RANGE       7
`define RC_START_EN    6
`define RC_RUNNING     5
`define RC_STOP_ERR    4
`define RC_PARITY_SEL  3
`define RC_NINTH       2
`define RC_END         1
`define RC_END_IE      0

// Transmit control fields
`define TC_RUN         7
`define TC_NINE_SEL    6
`define TC_DRIVE       5
`define TC_CMOS        4
`define TC_SEVEN_SEL   3
`define TC_NINTH       2
`define TC_EMPTY       1
`define TC_EMPTY_IE    0

// Mode select fields
`define MS_OP_HI       4
`define MS_OP_LO       3
`define MS_TX_END      1

// Port direction fields
`define PD_TX          0
`define PD_RX          1

// Timing: clock rate and fixed rates in bits per second
`define CLK_HZ         125000000
`define RATE_HI_BPS    9600
`define RATE_MID_BPS   4800
`define RATE_LO_BPS    2400
// Half-bit threshold in thirds of a cycle for the accumulator
`define HALF_LIM(bps)  ((`CLK_HZ * 3) / (2 * (bps)))

// Bus responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// ### rtl/baud_gen.v
// Fractional half-bit tick generator stepping by thirds of a cycle
`timescale 1ns/10ps
module baud_gen #(
  parameter LIM_W = 18
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             run,     // Counter held at zero when low
  input  wire [LIM_W-1:0] limit,   // Half-bit length in thirds of a cycle
  output reg              tick     // One-cycle pulse per half bit
);

  reg  [LIM_W:0] acc_q;            // Phase accumulator
  wire [LIM_W:0] sum = acc_q + {{(LIM_W-1){1'b0}}, 2'b11}; // Three thirds per cycle

  // Accumulate and wrap; restart whenever the user stops
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      acc_q <= {(LIM_W+1){1'b0}};
      tick  <= 1'b0;
    end else if (sum >= {1'b0, limit}) begin
      acc_q <= sum - {1'b0, limit};
      tick  <= 1'b1;
    end else begin
      acc_q <= sum;
      tick  <= 1'b0;
    end
  end

endmodule // baud_gen

// ### rtl/start_edge.v
// Falling-edge detector on the receive input
`timescale 1ns/10ps
module start_edge (
  input  wire aclk,
  input  wire aresetn,
  input  wire rx_in,    // Receive line, synchronous
  output wire fall      // High in the cycle the line drops
);

  reg prev_q;           // Line level one cycle ago

  // Track line, idle high
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= rx_in;
    end
  end

  assign fall = prev_q & ~rx_in;

endmodule // start_edge

// ### rtl/async_serial_port_control.v
// Full-duplex asynchronous serial port with AXI4-Lite register access
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module async_serial_port_control #(
  parameter ADDR_W = 18
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              subclock_div2,
  input  wire              rx_i,
  output reg               tx_o,
  output reg               tx_oe_n,
  output wire              rx_irq,
  output wire              tx_irq
);

  localparam integer LIM_HI  = `HALF_LIM(`RATE_HI_BPS);  // Fixed rate 1
  localparam integer LIM_MID = `HALF_LIM(`RATE_MID_BPS); // Fixed rate 2
  localparam integer LIM_LO  = `HALF_LIM(`RATE_LO_BPS);  // Fixed rate 3

  // Bit count of a frame from the length selections
  function [3:0] frame_bits;
    input len7;
    input extra;
    begin
      frame_bits = len7 ? 4'd9 : (extra ? 4'd11 : 4'd10);
    end
  endfunction

  // Register index decode
  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    reg   [15:0]       idx;
    begin
      idx = addr[17:2];
      case (idx)
        `RX_CTRL_IDX:  reg_sel = 3'd0;
        `TX_CTRL_IDX:  reg_sel = 3'd1;
        `BAUD_DIV_IDX: reg_sel = 3'd2;
        `TX_HOLD_IDX:  reg_sel = 3'd3;
        `RX_HOLD_IDX:  reg_sel = 3'd4;
        `MODE_SEL_IDX: reg_sel = 3'd5;
        `PORT_DIR_IDX: reg_sel = 3'd6;
        default:       reg_sel = 3'd7;
      endcase
    end
  endfunction

  // Receive control bits
  reg        rate_range_q;          // Coarse divider select
  reg        start_en_q;            // Start detection armed
  reg        rx_run_q;              // Reception in progress
  reg        stop_err_q;            // Sticky stop error
  reg        parity_sel_q;          // Odd parity when set
  reg        rx_ninth_q;            // Ninth bit or parity error
  reg        rx_end_q;              // Receive end flag
  reg        rx_end_ie_q;           // Receive end interrupt enable
  // Transmit control bits
  reg        tx_run_q;              // Transmit run
  reg        nine_sel_q;            // Nine-bit select
  reg        tx_drive_q;            // Drive transmit pin
  reg        tx_cmos_q;             // Push-pull when set
  reg        seven_sel_q;           // Seven-bit select
  reg        tx_ninth_q;            // Transmit bit 8
  reg        tx_empty_q;            // Transmit buffer empty
  reg        tx_empty_ie_q;         // Empty interrupt enable
  // Data and mode registers
  reg  [7:0] baud_q;                // Baud divider
  reg  [7:0] tx_hold_q;             // Transmit holding
  reg  [7:0] rx_hold_q;             // Receive holding
  reg  [7:0] mode_q;                // Mode select
  reg  [7:0] port_dir_q;            // Port direction
  // Transmit engine
  reg [10:0] tx_sh_q;               // Transmit shifter
  reg        tx_busy_q;             // Frame on the wire
  reg        tx_phase_q;            // Second half of bit
  reg  [3:0] tx_cnt_q;              // Bits sent
  reg        tx_restart_q;          // Continuous restart pending
  // Receive engine
  reg [10:0] rx_sh_q;               // Receive shifter
  reg  [4:0] rx_half_q;             // Half-bits elapsed
  // Bus slave state
  reg              aw_v_q;          // Write address held
  reg [ADDR_W-1:0] aw_addr_q;       // Held write address
  reg              w_v_q;           // Write data held
  reg  [7:0]       w_data_q;        // Held write byte
  reg              w_strb_q;        // Held lane 0 strobe

  // Frame format; length bits ignored in fixed-rate mode
  wire       fixed   = |mode_q[`MS_OP_HI:`MS_OP_LO];
  wire       len7    = seven_sel_q & ~nine_sel_q & ~fixed;
  wire       len9    = nine_sel_q & ~seven_sel_q & ~fixed;
  wire       par     = nine_sel_q & seven_sel_q & ~fixed;
  wire [3:0] nbits   = frame_bits(len7, len9 | par);
  wire [3:0] tx_nbits = nbits + {3'b000, fixed};      // Second stop bit at fixed rates
  wire       tx_par  = (^tx_hold_q) ^ parity_sel_q;

  // Half-bit threshold for both generators
  wire [8:0]  n_plus  = {1'b0, baud_q} + 9'h001;
  reg  [17:0] lim;
  always @* begin
    case (mode_q[`MS_OP_HI:`MS_OP_LO])
      2'b01:   lim = LIM_HI[17:0];
      2'b10:   lim = LIM_MID[17:0];
      2'b11:   lim = LIM_LO[17:0];
      default: lim = rate_range_q ? {5'h00, n_plus, 4'h0} : {7'h00, n_plus, 2'h0};
    endcase
  end
  // Subclock halving doubles the bit time of fixed rates
  wire [17:0] half_lim = (fixed && subclock_div2) ? {lim[16:0], 1'b0} : lim;

  wire tx_tick;                     // Transmit half-bit pulse
  wire rx_tick;                     // Receive half-bit pulse
  wire rx_fall;                     // Start edge

  baud_gen #(.LIM_W(18)) u_tx_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (tx_run_q | tx_busy_q), // Count from the run edge, full start bit
    .limit   (half_lim),
    .tick    (tx_tick)
  );

  baud_gen #(.LIM_W(18)) u_rx_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (rx_run_q),
    .limit   (half_lim),
    .tick    (rx_tick)
  );

  start_edge u_start (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rx_in   (rx_i),
    .fall    (rx_fall)
  );

  // Bus handshakes
  assign s_axi_awready = ~aw_v_q;
  assign s_axi_wready  = ~w_v_q;
  assign s_axi_arready = ~s_axi_rvalid;
  wire       wr_fire = aw_v_q & w_v_q & ~s_axi_bvalid;
  wire [2:0] wsel    = reg_sel(aw_addr_q);
  wire       wr      = wr_fire & w_strb_q;
  wire       wr_rxc  = wr && (wsel == 3'd0);
  wire       wr_txc  = wr && (wsel == 3'd1);
  wire [7:0] wd      = w_data_q;

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q       <= 1'b0;
      aw_addr_q    <= {ADDR_W{1'b0}};
      w_v_q        <= 1'b0;
      w_data_q     <= 8'h00;
      w_strb_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_v_q) begin
        aw_v_q    <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_v_q) begin
        w_v_q    <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_v_q       <= 1'b0;
        w_v_q        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 3'd7) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data selection; shifters have no address
  wire [2:0] rsel = reg_sel(s_axi_araddr);
  reg  [7:0] rd_val;
  always @* begin
    case (rsel)
      3'd0:    rd_val = {rate_range_q, start_en_q, rx_run_q, stop_err_q,
                         parity_sel_q, rx_ninth_q, rx_end_q, rx_end_ie_q};
      3'd1:    rd_val = {tx_run_q, nine_sel_q, tx_drive_q, tx_cmos_q,
                         seven_sel_q, tx_ninth_q, tx_empty_q, tx_empty_ie_q};
      3'd2:    rd_val = baud_q;
      3'd3:    rd_val = tx_hold_q;
      3'd4:    rd_val = rx_hold_q;
      3'd5:    rd_val = mode_q;
      3'd6:    rd_val = port_dir_q;
      default: rd_val = 8'h00;
    endcase
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= (rsel == 3'd7) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Transmit frame timing
  wire tx_start = tx_run_q & ~tx_busy_q;
  wire tx_bit   = tx_busy_q & tx_tick & tx_phase_q;
  wire tx_last  = tx_bit && (tx_cnt_q == tx_nbits - 4'd1);
  wire tx_ext   = par ? tx_par : tx_ninth_q;
  wire [10:0] tx_frame = len7 ? {3'b111, tx_hold_q[6:0], 1'b0} :
                         ((len9 | par) ? {1'b1, tx_ext, tx_hold_q, 1'b0} :
                                         {2'b11, tx_hold_q, 1'b0});

  // Transmit engine and its control bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_sh_q      <= 11'h7ff;
      tx_busy_q    <= 1'b0;
      tx_phase_q   <= 1'b0;
      tx_cnt_q     <= 4'h0;
      tx_restart_q <= 1'b0;
      tx_run_q     <= 1'b0;
      tx_empty_q   <= 1'b0;
      {nine_sel_q, tx_drive_q, tx_cmos_q, seven_sel_q} <= 4'h0;
      {tx_ninth_q, tx_empty_ie_q} <= 2'b00;
    end else begin
      tx_restart_q <= tx_last & ~tx_empty_q;
      if (wr_txc) begin
        {nine_sel_q, tx_drive_q, tx_cmos_q, seven_sel_q} <= wd[6:3];
        {tx_ninth_q, tx_empty_ie_q} <= {wd[`TC_NINTH], wd[`TC_EMPTY_IE]};
      end
      // Run bit: software write, self clear, continuous set
      if (wr_txc) begin
        tx_run_q <= wd[`TC_RUN];
      end else if (tx_restart_q) begin
        tx_run_q <= 1'b1;
      end else if (tx_last) begin
        tx_run_q <= 1'b0;
      end
      // Empty flag: hardware set wins over write
      if (tx_start) begin
        tx_empty_q <= 1'b1;
      end else if (wr_txc) begin
        tx_empty_q <= wd[`TC_EMPTY];
      end
      if (tx_start) begin
        tx_sh_q    <= tx_frame;
        tx_busy_q  <= 1'b1;
        tx_phase_q <= 1'b0;
        tx_cnt_q   <= 4'h0;
      end else if (tx_busy_q && !tx_run_q) begin
        tx_busy_q <= 1'b0;
        tx_sh_q   <= 11'h7ff;
      end else if (tx_busy_q && tx_tick) begin
        tx_phase_q <= ~tx_phase_q;
        if (tx_phase_q) begin
          tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
          tx_cnt_q <= tx_cnt_q + 4'h1;
        end
        if (tx_last) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // Transmit pin drive
  wire pin_on = tx_drive_q & ~port_dir_q[`PD_TX];
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_o    <= 1'b1;
      tx_oe_n <= 1'b1;
    end else begin
      tx_o    <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      tx_oe_n <= ~(pin_on & (tx_cmos_q | (tx_busy_q & ~tx_sh_q[0])));
    end
  end

  // Receive sampling: every other half-bit, first at mid start bit
  wire        rx_samp   = rx_run_q & rx_tick & ~rx_half_q[0];
  wire        rx_last   = rx_samp && (rx_half_q[4:1] == nbits - 4'd1);
  wire [10:0] rx_cat    = {rx_i, rx_sh_q[10:1]};
  wire [10:0] rx_frame  = rx_cat >> (4'd11 - nbits);
  wire [7:0]  rx_data   = len7 ? {1'b0, rx_frame[7:1]} : rx_frame[8:1];
  wire        rx_perr   = rx_frame[9] ^ (^rx_frame[8:1]) ^ parity_sel_q;

  // Receive engine and its control bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_q      <= 11'h000;
      rx_half_q    <= 5'h00;
      rx_run_q     <= 1'b0;
      rx_hold_q    <= 8'h00;
      {rate_range_q, start_en_q, parity_sel_q, rx_end_ie_q} <= 4'h0;
      {stop_err_q, rx_ninth_q, rx_end_q} <= 3'b000;
    end else begin
      if (wr_rxc) begin
        {rate_range_q, start_en_q} <= wd[7:6];
        {parity_sel_q, rx_end_ie_q} <= {wd[`RC_PARITY_SEL], wd[`RC_END_IE]};
      end
      if (wr && wsel == 3'd4) begin
        rx_hold_q <= wd;
      end
      // Running flag: edge sets, stop bit or software clears
      if (wr_rxc && !wd[`RC_RUNNING]) begin
        rx_run_q <= 1'b0;
      end else if (start_en_q && !rx_run_q && rx_fall) begin
        rx_run_q  <= 1'b1;
        rx_half_q <= 5'h00;
      end else if (rx_last) begin
        rx_run_q <= 1'b0;
      end else if (rx_run_q && rx_tick) begin
        rx_half_q <= rx_half_q + 5'h01;
      end
      if (rx_samp) begin
        rx_sh_q <= rx_cat;
      end
      // Frame end: hardware sets win over writes
      if (rx_last) begin
        rx_hold_q <= rx_data;
        rx_end_q  <= 1'b1;
        if (!rx_i) begin
          stop_err_q <= 1'b1;
        end else if (wr_rxc) begin
          stop_err_q <= wd[`RC_STOP_ERR];
        end
        if (len9) begin
          rx_ninth_q <= rx_frame[9];
        end else if (par) begin
          rx_ninth_q <= rx_perr;
        end else if (wr_rxc) begin
          rx_ninth_q <= wd[`RC_NINTH];
        end
      end else if (wr_rxc) begin
        rx_end_q   <= wd[`RC_END];
        stop_err_q <= wd[`RC_STOP_ERR];
        rx_ninth_q <= wd[`RC_NINTH];
      end
    end
  end

  // Plain registers and the transmit end flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_q     <= `CTRL_RESET;
      tx_hold_q  <= `CTRL_RESET;
      mode_q     <= `CTRL_RESET;
      port_dir_q <= `CTRL_RESET;
    end else begin
      if (wr && wsel == 3'd2) begin
        baud_q <= wd;
      end
      if (wr && wsel == 3'd3) begin
        tx_hold_q <= wd;
      end
      if (wr && wsel == 3'd6) begin
        port_dir_q <= wd;
      end
      if (wr && wsel == 3'd5) begin
        mode_q <= wd;
      end
      if (tx_last) begin
        mode_q[`MS_TX_END] <= 1'b1;
      end
    end
  end

  // Interrupt requests
  assign rx_irq = rx_end_q & rx_end_ie_q;
  assign tx_irq = tx_empty_q & tx_empty_ie_q;

endmodule // async_serial_port_control

// ### sim/async_serial_port_control_checker.sv
// Port-level timing checks for the serial port
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        tx_o,
  input wire        rx_irq,
  input wire        tx_irq
);
  // One clock domain, reset disables all checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("no write response");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_r_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_r_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
  a_rx_irq_fall: assert property ($fell(rx_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("receive request cleared without write");
  a_tx_irq_fall: assert property ($fell(tx_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("transmit request cleared without write");
  a_bit_min_len: assert property ($fell(tx_o) |=> !tx_o [*4])
    else $error("transmit bit too short");
endmodule // serial_port_checker

bind async_serial_port_control serial_port_checker chk_u (.*);

// ### sim/serial_node.sv
// Remote serial node: frame sender and transmit line decoder
`timescale 1ns/10ps
module serial_node (
  input  wire       aclk,
  input  wire       tx_o,
  input  wire       tx_oe_n,
  input  wire [3:0] nb,       // Data bits per frame incl. ninth
  output reg        rx_line,  // Device receive pin
  output reg  [9:0] word,     // Last frame, stop bit above data
  output int        frames    // Frames decoded
);
  localparam int BITC = 8;  // Bit time at divider 2, fine range
  wire line = tx_oe_n ? 1'b1 : tx_o;  // Pull-up while released
  initial begin
    rx_line = 1'b1;
    word = 0;
    frames = 0;
  end
  // One frame, LSB first, chosen stop level
  task automatic send(input [8:0] d, input stp);
    rx_line <= 1'b0;
    repeat (BITC) @(posedge aclk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (BITC) @(posedge aclk);
    end
    rx_line <= stp;
    repeat (BITC) @(posedge aclk);
    rx_line <= 1'b1;
    repeat (BITC) @(posedge aclk);
  endtask
  // Mid-bit sampling of the transmit line
  always begin
    @(negedge line);
    word = 0;
    repeat (BITC / 2) @(posedge aclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (BITC) @(posedge aclk);
      word[i] = line;
    end
    frames++;
  end
endmodule // serial_node

// ### sim/testbench.sv
// Self-checking bench for the serial port
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module testbench;
  logic        aclk = 0, aresetn = 0, subclock_div2 = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [3:0]  s_axi_wstrb = 4'hf, nb = 8;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         rx_i, tx_o, tx_oe_n, rx_irq, tx_irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [2:0]   ev = {tx_oe_n, tx_irq, rx_irq};  // Watched events
  int          err_count = 0, samples_checked = 0, k, f;
  localparam [15:0] RXC = `RX_CTRL_IDX, TXC = `TX_CTRL_IDX;
  localparam [15:0] TXH = `TX_HOLD_IDX, RXH = `RX_HOLD_IDX;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [1:0] r;} reg_t;
  typedef struct {logic [7:0] len; logic par; logic [3:0] n; logic [9:0] txw;
                  logic [8:0] rxs; logic [7:0] hold; logic nin;} mode_t;
  // Register rows: index, data, response
  reg_t rows[5] = '{'{`BAUD_DIV_IDX, 8'h02, 2'b00}, '{TXH, 8'ha5, 2'b00},
    '{`MODE_SEL_IDX, 8'he0, 2'b00}, '{`PORT_DIR_IDX, 8'h00, 2'b00}, '{16'h0000, 8'hff, 2'b10}};
  // Frame formats: 8, 7, 9, parity even, parity odd
  mode_t md[5] = '{'{8'h00, 1'b0, 8, 10'h15a, 9'h0a5, 8'ha5, 1'b0},
    '{8'h08, 1'b0, 7, 10'h0da, 9'h0a5, 8'h25, 1'b0},
    '{8'h40, 1'b0, 9, 10'h35a, 9'h1a5, 8'ha5, 1'b1},
    '{8'h48, 1'b0, 9, 10'h25a, 9'h1a5, 8'ha5, 1'b1},
    '{8'h48, 1'b1, 9, 10'h35a, 9'h1a5, 8'ha5, 1'b0}};

  async_serial_port_control dut_u (.*);
  serial_node node_u (.aclk, .tx_o, .tx_oe_n, .nb, .rx_line(rx_i), .word(), .frames());

  always #4 aclk = ~aclk;  // 125 MHz

  task stop_test;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write, address and data offered together
  task wr(input [15:0] i, input [7:0] d, input [1:0] er = 2'b00);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    repeat (100) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb && s_axi_bready) begin
        s_axi_bready <= 0;
        chk("bresp", er, rs);
        return;
      end
      // Ready raised once valid is seen, so the response stalls a cycle
      if (tb) s_axi_bready <= 1;
    end
    err_count++;
    stop_test();
  endtask
  // Bus read, masked compare unless quiet
  task rd(input [15:0] i, input [7:0] m, input [7:0] e, input [1:0] er = 2'b00, input q = 0);
    logic ta, tb;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    repeat (100) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
      if (tb && s_axi_rready) begin
        s_axi_rready <= 0;
        if (!q) chk("rdata", {24'h0, e}, rv & {24'h0, m});
        if (!q) chk("rresp", er, rs);
        return;
      end
      if (tb) s_axi_rready <= 1;
    end
    err_count++;
    stop_test();
  endtask
  task poll(input [15:0] i, input [7:0] m);
    repeat (100) begin
      rd(i, 0, 0, 0, 1);
      if ((rv[7:0] & m) === 8'h00) return;
    end
    err_count++;
    stop_test();
  endtask
  task wt(input int b, input logic v);
    repeat (2000) begin
      @(posedge aclk);
      if (ev[b] === v) return;
    end
    err_count++;
    stop_test();
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    chk("idle line", 3'b100, ev);
    rd(RXC, 8'hff, 8'h00);
    rd(TXC, 8'hff, 8'h00);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d, rows[r].r);
      rd(rows[r].a, 8'hff, rows[r].r == 0 ? rows[r].d : 8'h00, rows[r].r);
    end
    foreach (md[r]) begin
      nb <= md[r].n;
      wr(RXC, {4'h4, md[r].par, 3'b001});
      wr(TXH, 8'h5a);
      wr(TXC, 8'hb5 | md[r].len);
      wt(1, 1);
      node_u.send(md[r].rxs, 1);
      wt(0, 1);
      poll(TXC, 8'h80);
      chk("tx frame", md[r].txw, node_u.word);
      rd(RXH, 8'hff, md[r].hold);
      rd(RXC, md[r].n == 9 ? 8'h36 : 8'h32, {5'h0, md[r].nin, 2'b10});
      wr(RXC, 8'h00);
      wr(TXC, 8'h30);
      chk("irq", 0, ev[1:0]);
    end
    nb <= 8;
    wr(RXC, 8'h41);
    node_u.send(9'h0c3, 0);
    wt(0, 1);
    rd(RXC, 8'h32, 8'h12);
    wr(RXC, 8'h00);
    rd(RXC, 8'h10, 8'h00);
    // Continuous: reload and clear empty while running
    f = node_u.frames;
    wr(TXH, 8'h5a);
    wr(TXC, 8'hb1);
    wt(1, 1);
    wr(TXH, 8'h3c);
    wr(TXC, 8'hb1);
    wt(1, 1);
    poll(TXC, 8'h80);
    chk("frames", f + 2, node_u.frames);
    chk("second frame", 10'h13c, node_u.word);
    // Abort mid-frame
    wr(TXH, 8'h00);
    wr(TXC, 8'hb0);
    repeat (30) @(posedge aclk);
    wr(TXC, 8'h30);
    repeat (2) @(posedge aclk);
    chk("line after abort", 1, tx_o);
    rd(TXC, 8'h80, 8'h00);
    repeat (150) @(posedge aclk);
    // Fixed rate with halved subclock: start bit length
    subclock_div2 <= 1;
    wr(`MODE_SEL_IDX, 8'h08);
    wr(TXH, 8'hff);
    wr(TXC, 8'hb0);
    k = 0;
    repeat (26100) begin
      @(posedge aclk);
      if (tx_o === 1'b0) k++;
    end
    f = `CLK_HZ * 2 / `RATE_HI_BPS;
    chk("fixed start bit", 1, k >= f && k <= f + 1);
    wr(TXC, 8'h30);
    subclock_div2 <= 0;
    wr(`MODE_SEL_IDX, 8'h00);
    // Coarse range at divider 2: 32-cycle bits
    wr(RXC, 8'h80);
    wr(TXC, 8'hb0);
    k = 0;
    repeat (200) begin
      @(posedge aclk);
      if (tx_o === 1'b0) k++;
    end
    chk("coarse start bit", 32, k);
    poll(TXC, 8'h80);
    // Pin drive blocked by direction bit
    f = node_u.frames;
    k = 0;
    wr(`PORT_DIR_IDX, 8'h01);
    wr(TXC, 8'hb0);
    repeat (120) begin
      @(posedge aclk);
      if (tx_oe_n !== 1'b1) k++;
    end
    chk("enable low cycles", 0, k);
    chk("frames", f, node_u.frames);
    stop_test();
  end
  // Overall run limit
  initial begin
    repeat (100000) @(posedge aclk);
    err_count++;
    stop_test();
  end
endmodule // testbench
